// File: verilog/uart_frame_check_addr_match.sv
// Serial port with framing-error detection and automatic address recognition.
// Assumes an AXI4-Lite master on clk and a line input synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module uart_frame_check_addr_match
  import uart_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output var  logic          s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output var  logic          s_axi_wready,
  output var  logic [1:0]    s_axi_bresp,
  output var  logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output var  logic          s_axi_arready,
  output var  logic [31:0]   s_axi_rdata,
  output var  logic [1:0]    s_axi_rresp,
  output var  logic          s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          serial_in,
  output var  logic          serial_out,
  output var  logic          irq
);
  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          aw_rdy;
    logic          w_rdy;
    logic          ar_rdy;
    logic          aw_have;
    logic          w_have;
    logic [AW-1:0] awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [7:0]    serial_control;
    logic          framing_error_flag;
    logic [7:0]    power_control;
    logic [7:0]    slave_address;
    logic [7:0]    slave_address_mask;
    logic [7:0]    rx_buf;
    logic [15:0]   rx_div;
    logic [15:0]   tx_div;
    logic [2:0]    irq_sts;
    logic [2:0]    irq_en;
    logic          irq;
    logic          tx_go;
    logic [7:0]    tx_byte;
  } top_st_t;
  top_st_t s_reg;
  top_st_t s_next;

  rx_frame_t rx_frame;
  logic      rx_last_p;
  logic      rx_stop_p;
  logic      tx_busy;
  logic      tx_done_p;
  logic      txd_core;

  // Compares a against b only where m holds ones.
  function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] m);
    masked_eq = ((a ^ b) & m) == 8'h00;
  endfunction

  // Tells whether a byte address selects the register with index idx.
  function automatic logic is_reg(input logic [AW-1:0] a, input logic [9:0] idx);
    is_reg = a[AW-1:2] == idx;
  endfunction

  // ----------------------------------------------------------------
  // Receive decision
  // ----------------------------------------------------------------
  mode_t      mode;
  logic       fes_on;
  logic       mpe_on;
  logic       ninth;
  logic [7:0] bcast;
  logic       addr_hit;
  logic       frame_end;
  logic       accept;
  logic       ferr_event;

  assign mode   = mode_t'({s_reg.serial_control[SC_BIT7], s_reg.serial_control[SC_SM1]});
  assign fes_on = s_reg.power_control[PC_FES] && (mode != MODE0);
  assign mpe_on = s_reg.serial_control[SC_MPE] && (mode != MODE0);
  assign ninth  = (mode == MODE1) ? rx_frame.stop_ok : rx_frame.bit9;
  assign bcast  = s_reg.slave_address | s_reg.slave_address_mask;
  assign addr_hit = masked_eq(rx_frame.data, s_reg.slave_address, s_reg.slave_address_mask)
                 || masked_eq(rx_frame.data, bcast, bcast);
  // Mode 1 filtering must wait for the stop bit since it stands in for the ninth bit.
  assign frame_end = (fes_on || (mpe_on && mode == MODE1)) ? rx_stop_p : rx_last_p;
  assign accept   = frame_end && (!mpe_on || (ninth && addr_hit));
  assign ferr_event = fes_on && rx_stop_p && !rx_frame.stop_ok;

  uart_rx_core u_rx (
    .clk    (clk),
    .rst_b  (rst_b),
    .en     (s_reg.serial_control[SC_REN] && (mode != MODE0)),
    .nine   (mode[1]),
    .div    (s_reg.rx_div),
    .rxd    (serial_in),
    .frame  (rx_frame),
    .last_p (rx_last_p),
    .stop_p (rx_stop_p)
  );

  // The transmitter has its own divisor so both directions may differ in rate.
  uart_tx_core u_tx (
    .clk    (clk),
    .rst_b  (rst_b),
    .start  (s_reg.tx_go),
    .nine   (mode[1]),
    .bit9   (s_reg.serial_control[SC_TB8]),
    .data   (s_reg.tx_byte),
    .div    (s_reg.tx_div),
    .txd    (txd_core),
    .busy   (tx_busy),
    .done_p (tx_done_p)
  );

  // ----------------------------------------------------------------
  // Register bus and flags
  // ----------------------------------------------------------------
  logic [31:0]   rd_val;
  logic          rd_ok;
  logic [AW-1:0] wa;
  logic          wr_do;
  logic          wr_ok;
  logic [7:0]    wb;
  logic [2:0]    ev;

  always_comb
  begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    if (is_reg(s_axi_araddr, IDX_SER_CTRL))
      rd_val[7:0] = s_reg.power_control[PC_FES]
                  ? {s_reg.framing_error_flag, s_reg.serial_control[6:0]}
                  : s_reg.serial_control;
    else if (is_reg(s_axi_araddr, IDX_PWR_CTRL))
      rd_val[7:0] = s_reg.power_control;
    else if (is_reg(s_axi_araddr, IDX_SER_DATA))
      rd_val[7:0] = s_reg.rx_buf;
    else if (is_reg(s_axi_araddr, IDX_SLV_ADDR))
      rd_val[7:0] = s_reg.slave_address;
    else if (is_reg(s_axi_araddr, IDX_SMASK))
      rd_val[7:0] = s_reg.slave_address_mask;
    else if (is_reg(s_axi_araddr, IDX_BAUD))
      rd_val = {s_reg.tx_div, s_reg.rx_div};
    else if (is_reg(s_axi_araddr, IDX_IRQ_STS))
      rd_val[2:0] = s_reg.irq_sts;
    else if (is_reg(s_axi_araddr, IDX_IRQ_EN))
      rd_val[2:0] = s_reg.irq_en;
    else if (!is_reg(s_axi_araddr, IDX_IRQ_CLR))
      rd_ok = 1'b0;
  end

  assign wa    = s_reg.awaddr;
  assign wr_do = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
  assign wb    = s_reg.wstrb[0] ? s_reg.wdata[7:0] : 8'h00;
  assign ev    = {ferr_event, tx_done_p, accept};

  always_comb
  begin
    s_next       = s_reg;
    s_next.tx_go = 1'b0;
    wr_ok        = 1'b0;
    if (s_axi_awvalid && s_reg.aw_rdy)
    begin
      s_next.aw_have = 1'b1;
      s_next.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.w_rdy)
    begin
      s_next.w_have = 1'b1;
      s_next.wdata  = s_axi_wdata;
      s_next.wstrb  = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;
    if (wr_do)
    begin
      s_next.aw_have = 1'b0;
      s_next.w_have  = 1'b0;
      s_next.bvalid  = 1'b1;
      wr_ok          = 1'b1;
      if (s_reg.wstrb[0] && is_reg(wa, IDX_SER_CTRL))
      begin
        s_next.serial_control = wb;
        if (s_reg.power_control[PC_FES])
        begin
          s_next.serial_control[SC_BIT7] = s_reg.serial_control[SC_BIT7];
          s_next.framing_error_flag      = wb[SC_BIT7];
        end
      end
      else if (s_reg.wstrb[0] && is_reg(wa, IDX_PWR_CTRL))
        s_next.power_control = wb;
      else if (s_reg.wstrb[0] && is_reg(wa, IDX_SER_DATA))
      begin
        // A write while the transmitter is busy is dropped rather than corrupting a frame.
        s_next.tx_go   = !tx_busy;
        s_next.tx_byte = wb;
      end
      else if (s_reg.wstrb[0] && is_reg(wa, IDX_SLV_ADDR))
        s_next.slave_address = wb;
      else if (s_reg.wstrb[0] && is_reg(wa, IDX_SMASK))
        s_next.slave_address_mask = wb;
      else if (is_reg(wa, IDX_BAUD))
        for (int i = 0; i < 4; i++)
        begin
          if (s_reg.wstrb[i])
          begin
            if (i < 2)
              s_next.rx_div[i*8 +: 8] = s_reg.wdata[i*8 +: 8];
            else
              s_next.tx_div[(i-2)*8 +: 8] = s_reg.wdata[i*8 +: 8];
          end
        end
      else if (s_reg.wstrb[0] && is_reg(wa, IDX_IRQ_EN))
        s_next.irq_en = wb[2:0];
      else if (s_reg.wstrb[0] && is_reg(wa, IDX_IRQ_CLR))
        s_next.irq_sts = s_reg.irq_sts & ~wb[2:0];
      else if (!is_reg(wa, IDX_IRQ_STS) && !is_reg(wa, IDX_SER_CTRL)
               && !is_reg(wa, IDX_PWR_CTRL) && !is_reg(wa, IDX_SER_DATA)
               && !is_reg(wa, IDX_SLV_ADDR) && !is_reg(wa, IDX_SMASK)
               && !is_reg(wa, IDX_IRQ_EN) && !is_reg(wa, IDX_IRQ_CLR))
        wr_ok = 1'b0;
      s_next.bresp = wr_ok ? RESP_OK : RESP_ERR;
    end
    // Hardware events are applied after software writes so a set wins over a clear.
    if (accept)
    begin
      s_next.rx_buf                     = rx_frame.data;
      s_next.serial_control[SC_RXOK]    = 1'b1;
      s_next.serial_control[SC_RX9]     = ninth;
    end
    if (tx_done_p)
      s_next.serial_control[SC_TI] = 1'b1;
    if (ferr_event)
      s_next.framing_error_flag = 1'b1;
    s_next.irq_sts = s_next.irq_sts | ev;
    s_next.irq     = |(s_next.irq_sts & s_next.irq_en);
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_reg.ar_rdy)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_val;
      s_next.rresp  = rd_ok ? RESP_OK : RESP_ERR;
    end
    s_next.aw_rdy = !s_next.aw_have && !s_next.bvalid;
    s_next.w_rdy  = !s_next.w_have && !s_next.bvalid;
    s_next.ar_rdy = !s_next.rvalid;
  end

  always_ff @(posedge clk)
    if (!rst_b)
      s_reg <= '{serial_control: SC_RST, power_control: PC_RST,
                 slave_address: SLVA_RST, slave_address_mask: SMASK_RST,
                 rx_div: BIT_CYC_RST, tx_div: BIT_CYC_RST, default: '0};
    else
      s_reg <= s_next;

  // The line output is re-timed here so it comes straight from a flip-flop.
  always_ff @(posedge clk)
    if (!rst_b)
      serial_out <= 1'b1;
    else
      serial_out <= txd_core;

  assign s_axi_awready = s_reg.aw_rdy;
  assign s_axi_wready  = s_reg.w_rdy;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.ar_rdy;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign irq           = s_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_ferr_sticky: assert property (s_reg.framing_error_flag && !wr_do
                                  |=> s_reg.framing_error_flag)
    else $error("framing error flag dropped without a write");
  a_ferr_set: assert property (ferr_event |=> s_reg.framing_error_flag)
    else $error("invalid stop bit did not set framing error");
  a_ferr_gated: assert property ($rose(s_reg.framing_error_flag) && !$past(wr_do)
                                 |-> $past(s_reg.power_control[PC_FES]) && $past(mode) != MODE0)
    else $error("framing error set while checking was off");
  a_done_at_stop: assert property (accept && fes_on |-> rx_stop_p)
    else $error("receive done not at stop bit");
  a_addr_filter: assert property (accept && mpe_on |-> ninth && addr_hit)
    else $error("receive done for a foreign address");
  a_mode1_stop: assert property (accept && mpe_on && mode == MODE1 |-> rx_frame.stop_ok)
    else $error("mode 1 address accepted without stop bit");
  a_mode0_off: assert property (mode == MODE0 |-> !mpe_on && !fes_on)
    else $error("mode 0 enabled filtering or checking");
  a_ninth_store: assert property (accept && mode[1]
                                  |=> s_reg.serial_control[SC_RX9] == $past(ninth))
    else $error("received ninth bit not stored");
  a_reset_addr: assert property (!$past(rst_b) |-> s_reg.slave_address == 8'h00
                                 && s_reg.slave_address_mask == 8'h00)
    else $error("address registers not zero after reset");
  a_irq_follow: assert property (accept && s_reg.irq_en[IRQ_RX] |=> ##1 irq)
    else $error("receive event did not raise interrupt");

  c_addr_hit: cover property (accept && mpe_on);
  c_addr_miss: cover property (frame_end && mpe_on && ninth && !addr_hit);
  c_frame_err: cover property (ferr_event);
  c_tx_done: cover property (tx_done_p);
endmodule
`default_nettype wire

// File: verilog/uart_pkg.sv
// Constants, types and register map of the receive-enhanced serial port.
// Assumes a single 25 MHz clock and an AXI4-Lite master for software access.
`default_nettype none
package uart_pkg;
  localparam int          CLK_HZ       = 25000000;
  localparam int          BAUD_DEFAULT = 9600;
  localparam logic [15:0] BIT_CYC_RST  = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam int          AW           = 12;
  // Register indices; byte address is four times the index.
  localparam logic [9:0]  IDX_PWR_CTRL = 10'h087;
  localparam logic [9:0]  IDX_SER_CTRL = 10'h098;
  localparam logic [9:0]  IDX_SER_DATA = 10'h099;
  localparam logic [9:0]  IDX_SLV_ADDR = 10'h0a9;
  localparam logic [9:0]  IDX_SMASK    = 10'h0b9;
  localparam logic [9:0]  IDX_BAUD     = 10'h0c0;
  localparam logic [9:0]  IDX_IRQ_STS  = 10'h0c1;
  localparam logic [9:0]  IDX_IRQ_EN   = 10'h0c2;
  localparam logic [9:0]  IDX_IRQ_CLR  = 10'h0c3;
  // Serial control fields, and the FES field of power control.
  localparam int SC_BIT7 = 7;
  localparam int SC_SM1  = 6;
  localparam int SC_MPE  = 5;
  localparam int SC_REN  = 4;
  localparam int SC_TB8  = 3;
  localparam int SC_RX9  = 2;
  localparam int SC_TI   = 1;
  localparam int SC_RXOK = 0;
  localparam int PC_FES  = 6;
  // Interrupt status fields.
  localparam int IRQ_RX  = 0;
  localparam int IRQ_TX  = 1;
  localparam int IRQ_ERR = 2;
  // Reset values and bus response codes.
  localparam logic [7:0] SC_RST    = 8'h00;
  localparam logic [7:0] PC_RST    = 8'h00;
  localparam logic [7:0] SLVA_RST  = 8'h00;
  localparam logic [7:0] SMASK_RST = 8'h00;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  typedef enum logic [1:0] {MODE0 = 2'h0, MODE1 = 2'h1, MODE2 = 2'h2, MODE3 = 2'h3} mode_t;
  typedef enum logic [1:0] {LN_IDLE = 2'h0, LN_START = 2'h1, LN_DATA = 2'h3, LN_STOP = 2'h2}
    line_st_t;
  typedef struct packed {
    logic [7:0] data;
    logic       bit9;
    logic       stop_ok;
  } rx_frame_t;
endpackage
`default_nettype wire

// File: verilog/uart_rx_core.sv
// Asynchronous frame receiver: start check, 8 or 9 data bits, stop sample.
// Assumes the line input is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_core
  import uart_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        en,
  input  wire logic        nine,
  input  wire logic [15:0] div,
  input  wire logic        rxd,
  output var  rx_frame_t   frame,
  output var  logic        last_p,
  output var  logic        stop_p
);
  typedef struct packed {
    line_st_t    st;
    logic [15:0] cnt;
    logic [3:0]  bitn;
    logic [8:0]  sh;
    rx_frame_t   fr;
    logic        last_p;
    logic        stop_p;
  } rx_st_t;
  rx_st_t s_reg;
  rx_st_t s_next;

  always_comb
  begin
    s_next        = s_reg;
    s_next.last_p = 1'b0;
    s_next.stop_p = 1'b0;
    if (s_reg.cnt != 16'h0000)
      s_next.cnt = s_reg.cnt - 16'h0001;
    case (s_reg.st)
      LN_IDLE:
        if (en && !rxd)
        begin
          s_next.st  = LN_START;
          s_next.cnt = {1'b0, div[15:1]};
        end
      LN_START:
        if (s_reg.cnt == 16'h0000)
        begin
          s_next.st   = rxd ? LN_IDLE : LN_DATA;
          s_next.cnt  = div - 16'h0001;
          s_next.bitn = 4'h0;
        end
      LN_DATA:
        if (s_reg.cnt == 16'h0000)
        begin
          s_next.sh   = {rxd, s_reg.sh[8:1]};
          s_next.cnt  = div - 16'h0001;
          s_next.bitn = s_reg.bitn + 4'h1;
          if (s_reg.bitn == (nine ? 4'h8 : 4'h7))
          begin
            s_next.st      = LN_STOP;
            s_next.last_p  = 1'b1;
            s_next.fr.data = nine ? s_next.sh[7:0] : s_next.sh[8:1];
            s_next.fr.bit9 = nine & rxd;
          end
        end
      LN_STOP:
        if (s_reg.cnt == 16'h0000)
        begin
          s_next.st         = LN_IDLE;
          s_next.fr.stop_ok = rxd;
          s_next.stop_p     = 1'b1;
        end
      default:
        s_next.st = LN_IDLE;
    endcase
  end

  always_ff @(posedge clk)
    if (!rst_b)
      s_reg <= '0;
    else
      s_reg <= s_next;

  assign frame  = s_reg.fr;
  assign last_p = s_reg.last_p;
  assign stop_p = s_reg.stop_p;
endmodule
`default_nettype wire

// File: verilog/uart_tx_core.sv
// Asynchronous frame transmitter with its own bit time.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module uart_tx_core
  import uart_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic        nine,
  input  wire logic        bit9,
  input  wire logic [7:0]  data,
  input  wire logic [15:0] div,
  output var  logic        txd,
  output var  logic        busy,
  output var  logic        done_p
);
  typedef struct packed {
    line_st_t    st;
    logic [15:0] cnt;
    logic [3:0]  bitn;
    logic [10:0] sh;
    logic        txd;
    logic        done_p;
  } tx_st_t;
  tx_st_t s_reg;
  tx_st_t s_next;

  always_comb
  begin
    s_next        = s_reg;
    s_next.done_p = 1'b0;
    if (s_reg.cnt != 16'h0000)
      s_next.cnt = s_reg.cnt - 16'h0001;
    case (s_reg.st)
      LN_IDLE:
      begin
        s_next.txd = 1'b1;
        if (start)
        begin
          s_next.st   = LN_DATA;
          s_next.sh   = {1'b1, nine ? bit9 : 1'b1, data, 1'b0};
          s_next.bitn = nine ? 4'ha : 4'h9;
          s_next.cnt  = 16'h0000;
        end
      end
      LN_DATA, LN_STOP:
        if (s_reg.cnt == 16'h0000)
        begin
          s_next.txd  = s_reg.sh[0];
          s_next.sh   = {1'b1, s_reg.sh[10:1]};
          s_next.cnt  = div - 16'h0001;
          s_next.bitn = s_reg.bitn - 4'h1;
          if (s_reg.st == LN_STOP)
            s_next.st = LN_IDLE;
          else if (s_reg.bitn == 4'h0)
          begin
            s_next.st     = LN_STOP;
            s_next.done_p = 1'b1;
          end
        end
      default:
        s_next.st = LN_IDLE;
    endcase
  end

  always_ff @(posedge clk)
    if (!rst_b)
      s_reg <= '{st: LN_IDLE, txd: 1'b1, default: '0};
    else
      s_reg <= s_next;

  assign txd    = s_reg.txd;
  assign busy   = s_reg.st != LN_IDLE;
  assign done_p = s_reg.done_p;
endmodule
`default_nettype wire

// File: test/serial_master_model.sv
// Master serial node that drives the shared receive line of the port.
// Assumes the bench calls send; frames start on a clk edge and idle high.
`timescale 1ns/1ps
`default_nettype none
module serial_master_model
#(
  parameter int BIT_CYC = 16
)
(
  input  wire logic clk,
  output var  logic line
);
  // ----------------------------------------------------------------
  // Frame generator
  // ----------------------------------------------------------------
  // The line returns to its idle high level between frames, like a pull-up.
  initial line = 1'b1;

  // Nine-bit frames carry b9 as the address mark; mode 1 uses the stop bit.
  task automatic send(input logic [7:0] d, input logic nine, input logic b9,
                      input logic stop);
    logic [10:0] f;
    int          n;
    f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      line <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    @(posedge clk);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: test/tb_uart_frame_check_addr_match.sv
// Self-checking bench for the serial port with address recognition.
// Assumes a 25 MHz clock, AXI4-Lite access and the master line model.
`timescale 1ns/1ps
`default_nettype none
module tb_uart_frame_check_addr_match
  import uart_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic          clk = 1'b0;
  logic          rst_b = 1'b0;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid, irq, serial_in, serial_out;
  logic [31:0]   wdata = '0, rdata, d;
  logic [1:0]    bresp, rresp, r;
  int            fail_count = 0, checks_done = 0, cycles = 0;
  logic [8:0]    tbl [6] = '{9'h155, 9'h15e, 9'h1ff, 9'h056, 9'h157, 9'h156};
  logic          hit [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0]    msk [6] = '{8'hfc, 8'hfc, 8'hfc, 8'hfc, 8'hff, 8'hff};
  logic [9:0]    txf;

  always #20 clk = ~clk;

  serial_master_model #(.BIT_CYC(16)) serial_master_model_inst (.clk(clk), .line(serial_in));

  uart_frame_check_addr_match uart_frame_check_addr_match_inst (
    .clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_in(serial_in), .serial_out(serial_out), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Bus tasks and checking
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!(arready === 1'b1));
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic stop_test;
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang past the expected few thousand cycles counts as a mismatch.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(IDX_SLV_ADDR);
    chk("slave_address", d, 32'h0);
    rd(IDX_SMASK);
    chk("slave_address_mask", d, 32'h0);
    rd(10'h3ff);
    chk("unmapped_resp", {30'h0, r}, {30'h0, RESP_ERR});
    wr(10'h3ff, 32'h0);
    chk("unmapped_bresp", {30'h0, r}, {30'h0, RESP_ERR});
    wr(IDX_BAUD, 32'h0010_0010);
    chk("write_resp", {30'h0, r}, {30'h0, RESP_OK});
    wr(IDX_IRQ_EN, 32'h1);
    wr(IDX_SER_CTRL, 32'hf0);
    // Reset addresses are all don't-care, so any address frame matches.
    serial_master_model_inst.send(8'h33, 1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    rd(IDX_IRQ_STS);
    chk("rx_any_addr", d & 32'h1, 32'h1);
    chk("irq_level", {31'h0, irq}, 32'h1);
    rd(IDX_SER_CTRL);
    chk("ninth_bit", d & 32'h5, 32'h5);
    wr(IDX_IRQ_CLR, 32'h7);
    wr(IDX_SER_CTRL, 32'hf0);
    repeat (3) @(posedge clk);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    wr(IDX_SLV_ADDR, 32'h56);
    for (int i = 0; i < 6; i++)
    begin
      wr(IDX_SMASK, {24'h0, msk[i]});
      serial_master_model_inst.send(tbl[i][7:0], 1'b1, tbl[i][8], 1'b1);
      repeat (4) @(posedge clk);
      rd(IDX_IRQ_STS);
      chk("addr_match", d & 32'h1, {31'h0, hit[i]});
      rd(IDX_SER_DATA);
      if (hit[i])
        chk("addr_data", d, {24'h0, tbl[i][7:0]});
      wr(IDX_IRQ_CLR, 32'h7);
    end
    // Mode goes in before the select bit, since bit 7 then writes the flag instead.
    wr(IDX_SER_CTRL, 32'h50);
    wr(IDX_PWR_CTRL, 32'h40);
    serial_master_model_inst.send(8'h3c, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    rd(IDX_SER_CTRL);
    chk("frame_err_flag", d & 32'h80, 32'h80);
    wr(IDX_IRQ_CLR, 32'h7);
    serial_master_model_inst.send(8'hc3, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    rd(IDX_SER_CTRL);
    chk("flag_sticky", d & 32'h81, 32'h81);
    rd(IDX_IRQ_STS);
    chk("rx_valid_stop", d, 32'h1);
    rd(IDX_SER_DATA);
    chk("mode1_data", d, 32'hc3);
    wr(IDX_SER_CTRL, 32'h50);
    rd(IDX_SER_CTRL);
    chk("flag_clear", d & 32'h80, 32'h0);
    // Mode 1 filtering: the stop bit stands in for the address mark.
    wr(IDX_SER_CTRL, 32'h70);
    wr(IDX_IRQ_CLR, 32'h7);
    serial_master_model_inst.send(8'h56, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    rd(IDX_IRQ_STS);
    chk("mode1_bad_stop", d & 32'h1, 32'h0);
    serial_master_model_inst.send(8'h56, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    rd(IDX_IRQ_STS);
    chk("mode1_addr_hit", d & 32'h1, 32'h1);
    // Both directions at once, at different bit times.
    wr(IDX_SER_CTRL, 32'h50);
    wr(IDX_BAUD, 32'h0018_0010);
    wr(IDX_IRQ_CLR, 32'h7);
    wr(IDX_SER_DATA, 32'ha5);
    fork
      serial_master_model_inst.send(8'h69, 1'b0, 1'b0, 1'b1);
      begin
        while (serial_out !== 1'b0) @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
          repeat ((i == 0) ? 11 : 24) @(posedge clk);
          txf[i] = serial_out;
        end
      end
    join
    chk("tx_frame", {22'h0, txf}, {22'h0, 1'b1, 8'ha5, 1'b0});
    repeat (4) @(posedge clk);
    rd(IDX_SER_DATA);
    chk("duplex_rx", d, 32'h69);
    rd(IDX_IRQ_STS);
    chk("duplex_irq", d, 32'h3);
    stop_test();
  end
endmodule
`default_nettype wire
